// *** hdl/ccsb_defines.svh ***
// Purpose: Constants for the invert, compare-skip and BCD adjust decoder
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes:   Definitions only
`ifndef CCSB_DEFINES_SVH
`define CCSB_DEFINES_SVH

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define CCSB_INV_MASK     16'hFC00
`define CCSB_INV_CODE     16'h1C00
`define CCSB_SKIP_MASK    16'hFE00
`define CCSB_SKIP_EQ_CODE 16'h6200
`define CCSB_SKIP_GT_CODE 16'h6400
`define CCSB_SKIP_LT_CODE 16'h6000
`define CCSB_BCD_WORD     16'h0007

// ----------------------------------------------------------------
// Operand fields
// ----------------------------------------------------------------
`define CCSB_DEST_BIT     9
`define CCSB_BANK_BIT     8
`define CCSB_FILE_MSB     7

// ----------------------------------------------------------------
// Data memory addressing
// ----------------------------------------------------------------
`define CCSB_INDEX_LIMIT  8'h5F
`define CCSB_ACCESS_SPLIT 8'h60
`define CCSB_LOW_BANK     4'h0
`define CCSB_HIGH_BANK    4'hF

// ----------------------------------------------------------------
// Arithmetic
// ----------------------------------------------------------------
`define CCSB_BCD_LIMIT    5'h09
`define CCSB_BCD_FIX      5'h06
`define CCSB_SKIP_ONE     2'h1
`define CCSB_SKIP_TWO     2'h2
`define CCSB_SKIP_NONE    2'h0

`endif

// *** hdl/ccsb_pkg.sv ***
// Purpose: Types shared by the decoder core and its arithmetic unit
// Assumes: Constants come from ccsb_defines.svh
// Notes:   Holds types only
package ccsb_pkg;

  typedef enum logic [1:0] {
    CCSB_Q1,
    CCSB_Q2,
    CCSB_Q3,
    CCSB_Q4
  } ccsb_phase_type;

  typedef enum logic [2:0] {
    CCSB_OP_NONE,
    CCSB_OP_INVERT,
    CCSB_OP_SKIP_EQ,
    CCSB_OP_SKIP_GT,
    CCSB_OP_SKIP_LT,
    CCSB_OP_BCD
  } ccsb_op_type;

  typedef struct packed {
    ccsb_phase_type phase;
    ccsb_op_type    op;
    logic           dest;
    logic [7:0]     operand;
    logic [1:0]     skipLeft;
    logic [11:0]    memAddr;
    logic           memReadEn;
    logic [7:0]     memWrData;
    logic           memWrEn;
    logic [7:0]     accWrData;
    logic           accWrEn;
    logic           negFlag;
    logic           zeroFlag;
    logic           nzWrEn;
    logic           carryFlag;
    logic           carryWrEn;
    logic           discardNext;
    logic           cycleStart;
    logic           handled;
  } ccsb_state_type;

endpackage : ccsb_pkg

// *** hdl/ccsb_alu_if.sv ***
// Purpose: Carrier between the decoder core and its arithmetic unit
// Assumes: Purely combinational traffic
// Notes:   One modport per side
interface ccsb_alu_if;
  ccsb_pkg::ccsb_op_type op;
  logic [7:0]            operand;
  logic [7:0]            accum;
  logic                  carryIn;
  logic                  halfCarryIn;
  logic [7:0]            result;
  logic                  negative;
  logic                  zero;
  logic                  carryOut;
  logic                  skipTaken;

  modport core (
    output op,
    output operand,
    output accum,
    output carryIn,
    output halfCarryIn,
    input  result,
    input  negative,
    input  zero,
    input  carryOut,
    input  skipTaken
  );

  modport alu (
    input  op,
    input  operand,
    input  accum,
    input  carryIn,
    input  halfCarryIn,
    output result,
    output negative,
    output zero,
    output carryOut,
    output skipTaken
  );
endinterface : ccsb_alu_if

// *** hdl/ccsb_alu.sv ***
// Purpose: Result, flags and skip decision for the decoded operation
// Assumes: Operand and accumulator stable while the result is used
// Notes:   No storage
`include "ccsb_defines.svh"

module ccsb_alu (
  ccsb_alu_if.alu bus
);

  logic [8:0] diff;
  logic [4:0] lowSum;
  logic [4:0] highBase;
  logic [4:0] highSum;
  logic [7:0] bcdResult;

  always_comb begin
    diff = {1'b0, bus.operand} - {1'b0, bus.accum};

    lowSum = {1'b0, bus.operand[3:0]};
    if ((lowSum > `CCSB_BCD_LIMIT) || bus.halfCarryIn) begin
      lowSum = lowSum + `CCSB_BCD_FIX;
    end

    highBase = {1'b0, bus.operand[7:4]} + {4'h0, bus.halfCarryIn};
    highSum  = highBase;
    if ((highBase > `CCSB_BCD_LIMIT) || bus.carryIn) begin
      highSum = highBase + `CCSB_BCD_FIX;
    end
    bcdResult = {highSum[3:0], lowSum[3:0]};

    bus.result    = 8'h00;
    bus.carryOut  = bus.carryIn;
    bus.skipTaken = 1'b0;
    unique case (bus.op)
      ccsb_pkg::CCSB_OP_INVERT: begin
        bus.result = ~bus.operand;
      end
      ccsb_pkg::CCSB_OP_SKIP_EQ: bus.skipTaken = (diff == 9'h000);
      ccsb_pkg::CCSB_OP_SKIP_GT: bus.skipTaken = !diff[8] &&
                                                  (diff != 9'h000);
      ccsb_pkg::CCSB_OP_SKIP_LT: bus.skipTaken = diff[8];
      ccsb_pkg::CCSB_OP_BCD: begin
        bus.result   = bcdResult;
        bus.carryOut = highSum[4] | bus.carryIn;
      end
      ccsb_pkg::CCSB_OP_NONE: bus.result = 8'h00;
      default: bus.result = 8'h00;
    endcase

    bus.negative = bus.result[7];
    bus.zero     = (bus.result == 8'h00);
  end

endmodule : ccsb_alu

// *** hdl/ccsb_core.sv ***
// Purpose: Executes invert, compare-and-skip and BCD adjust instructions
// Assumes: Instruction word valid in Q1; file data valid in Q2;
//          accumulator and flags stable for the whole cycle
// Notes:   One instruction cycle is four clocks, Q1 to Q4
`include "ccsb_defines.svh"

// Summary of operation
// - Invert decoded from top bits 000111
// - Inverse goes to accumulator or file
// - Invert touches only negative and zero
// - Bank bit picks access bank or pointer
// - Extended mode low addresses use indexing
// - Equal compare skips next instruction
// - Greater compare skips next instruction
// - Less compare skips next instruction
// - Compares unsigned, no flags, no writes
// - Taken skip inserts one no-operation cycle
// - Skipped two-word instruction costs two cycles
// - Adjust low nibble by six when needed
// - Adjust high nibble with half carry, six
// - Adjust fixed word, one cycle, carry only
module ccsb_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] instrWord,
  input  wire logic        nextTwoWord,
  input  wire logic [7:0]  fileData,
  input  wire logic [7:0]  accumulatorReg,
  input  wire logic        carryIn,
  input  wire logic        halfCarryFlag,
  input  wire logic [3:0]  bankPointer,
  input  wire logic        extendedEn,
  input  wire logic [11:0] indexBase,
  output logic             cycleStart,
  output logic             handled,
  output logic [11:0]      memAddr,
  output logic             memReadEn,
  output logic [7:0]       memWrData,
  output logic             memWrEn,
  output logic [7:0]       accWrData,
  output logic             accWrEn,
  output logic             negFlag,
  output logic             zeroFlag,
  output logic             nzWrEn,
  output logic             carryFlag,
  output logic             carryWrEn,
  output logic             discardNext
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic ccsb_pkg::ccsb_op_type decodeOp(
    input logic [15:0] word
  );
    ccsb_pkg::ccsb_op_type op;
    op = ccsb_pkg::CCSB_OP_NONE;
    if ((word & `CCSB_INV_MASK) == `CCSB_INV_CODE) begin
      op = ccsb_pkg::CCSB_OP_INVERT;
    end else if ((word & `CCSB_SKIP_MASK) == `CCSB_SKIP_EQ_CODE) begin
      op = ccsb_pkg::CCSB_OP_SKIP_EQ;
    end else if ((word & `CCSB_SKIP_MASK) == `CCSB_SKIP_GT_CODE) begin
      op = ccsb_pkg::CCSB_OP_SKIP_GT;
    end else if ((word & `CCSB_SKIP_MASK) == `CCSB_SKIP_LT_CODE) begin
      op = ccsb_pkg::CCSB_OP_SKIP_LT;
    end else if (word == `CCSB_BCD_WORD) begin
      op = ccsb_pkg::CCSB_OP_BCD;
    end
    return op;
  endfunction : decodeOp

  function automatic logic [11:0] fileAddr(
    input logic [7:0]  f,
    input logic        bankSel,
    input logic [3:0]  ptr,
    input logic        ext,
    input logic [11:0] base
  );
    logic [11:0] addr;
    addr = {ptr, f};
    if (!bankSel) begin
      if (ext && (f <= `CCSB_INDEX_LIMIT)) begin
        addr = base + {4'h0, f};
      end else if (f < `CCSB_ACCESS_SPLIT) begin
        addr = {`CCSB_LOW_BANK, f};
      end else begin
        addr = {`CCSB_HIGH_BANK, f};
      end
    end
    return addr;
  endfunction : fileAddr

  function automatic logic isSkipOp(input ccsb_pkg::ccsb_op_type op);
    return (op == ccsb_pkg::CCSB_OP_SKIP_EQ) ||
           (op == ccsb_pkg::CCSB_OP_SKIP_GT) ||
           (op == ccsb_pkg::CCSB_OP_SKIP_LT);
  endfunction : isSkipOp

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccsb_pkg::ccsb_state_type cur;
  ccsb_pkg::ccsb_state_type next_cur;
  ccsb_pkg::ccsb_op_type    decoded;

  ccsb_alu_if aluBus ();

  ccsb_alu u_alu (
    .bus (aluBus.alu)
  );

  always_comb begin
    aluBus.op          = cur.op;
    aluBus.operand     = cur.operand;
    aluBus.accum       = accumulatorReg;
    aluBus.carryIn     = carryIn;
    aluBus.halfCarryIn = halfCarryFlag;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur           = cur;
    decoded            = decodeOp(instrWord);
    // Strobes last exactly one clock: write strobes in Q4, memReadEn in Q2
    next_cur.memWrEn   = 1'b0;
    next_cur.accWrEn   = 1'b0;
    next_cur.nzWrEn    = 1'b0;
    next_cur.carryWrEn = 1'b0;
    next_cur.memReadEn = 1'b0;
    next_cur.cycleStart = (cur.phase == ccsb_pkg::CCSB_Q4);

    unique case (cur.phase)
      ccsb_pkg::CCSB_Q1: begin
        next_cur.phase = ccsb_pkg::CCSB_Q2;
        if (cur.skipLeft != `CCSB_SKIP_NONE) begin
          next_cur.op      = ccsb_pkg::CCSB_OP_NONE;
          next_cur.handled = 1'b0;
        end else begin
          next_cur.op      = decoded;
          next_cur.handled = (decoded != ccsb_pkg::CCSB_OP_NONE);
          next_cur.dest    = instrWord[`CCSB_DEST_BIT];
          next_cur.memAddr = fileAddr(instrWord[`CCSB_FILE_MSB:0],
                                      instrWord[`CCSB_BANK_BIT],
                                      bankPointer, extendedEn,
                                      indexBase);
          next_cur.memReadEn = (decoded != ccsb_pkg::CCSB_OP_NONE) &&
                               (decoded != ccsb_pkg::CCSB_OP_BCD);
        end
      end
      ccsb_pkg::CCSB_Q2: begin
        next_cur.phase = ccsb_pkg::CCSB_Q3;
        // Adjust works on the accumulator, the rest on file data
        next_cur.operand = (cur.op == ccsb_pkg::CCSB_OP_BCD) ?
                           accumulatorReg : fileData;
      end
      ccsb_pkg::CCSB_Q3: begin
        next_cur.phase = ccsb_pkg::CCSB_Q4;
        unique case (cur.op)
          ccsb_pkg::CCSB_OP_INVERT: begin
            if (cur.dest) begin
              next_cur.memWrData = aluBus.result;
              next_cur.memWrEn   = 1'b1;
            end else begin
              next_cur.accWrData = aluBus.result;
              next_cur.accWrEn   = 1'b1;
            end
            next_cur.negFlag  = aluBus.negative;
            next_cur.zeroFlag = aluBus.zero;
            next_cur.nzWrEn   = 1'b1;
          end
          ccsb_pkg::CCSB_OP_BCD: begin
            next_cur.accWrData = aluBus.result;
            next_cur.accWrEn   = 1'b1;
            next_cur.carryFlag = aluBus.carryOut;
            next_cur.carryWrEn = 1'b1;
          end
          ccsb_pkg::CCSB_OP_SKIP_EQ,
          ccsb_pkg::CCSB_OP_SKIP_GT,
          ccsb_pkg::CCSB_OP_SKIP_LT,
          ccsb_pkg::CCSB_OP_NONE: next_cur.memWrEn = 1'b0;
          default: next_cur.memWrEn = 1'b0;
        endcase
      end
      ccsb_pkg::CCSB_Q4: begin
        next_cur.phase = ccsb_pkg::CCSB_Q1;
        if (cur.skipLeft != `CCSB_SKIP_NONE) begin
          next_cur.skipLeft    = cur.skipLeft - `CCSB_SKIP_ONE;
          next_cur.discardNext = (cur.skipLeft != `CCSB_SKIP_ONE);
        end else if (isSkipOp(cur.op) && aluBus.skipTaken) begin
          next_cur.skipLeft    = nextTwoWord ? `CCSB_SKIP_TWO :
                                               `CCSB_SKIP_ONE;
          next_cur.discardNext = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{phase: ccsb_pkg::CCSB_Q1, op: ccsb_pkg::CCSB_OP_NONE,
               default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  always_comb begin
    cycleStart  = cur.cycleStart;
    handled     = cur.handled;
    memAddr     = cur.memAddr;
    memReadEn   = cur.memReadEn;
    memWrData   = cur.memWrData;
    memWrEn     = cur.memWrEn;
    accWrData   = cur.accWrData;
    accWrEn     = cur.accWrEn;
    negFlag     = cur.negFlag;
    zeroFlag    = cur.zeroFlag;
    nzWrEn      = cur.nzWrEn;
    carryFlag   = cur.carryFlag;
    carryWrEn   = cur.carryWrEn;
    discardNext = cur.discardNext;
  end

endmodule : ccsb_core

// *** dv/ccsb_core_sva.sv ***
// Purpose: Port-level checks for the invert, compare-skip and adjust core
// Assumes: One instruction cycle is four clocks after reset release
// Notes:   Bound to ccsb_core
module ccsb_core_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] instrWord,
  input wire logic        nextTwoWord,
  input wire logic [3:0]  bankPointer,
  input wire logic        cycleStart,
  input wire logic        handled,
  input wire logic [11:0] memAddr,
  input wire logic        memReadEn,
  input wire logic        memWrEn,
  input wire logic        accWrEn,
  input wire logic        nzWrEn,
  input wire logic        carryWrEn,
  input wire logic        discardNext
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       go;
  logic       invOp;
  logic       cmpOp;
  logic [7:0] fileSel;
  assign go      = cycleStart && !discardNext;
  assign invOp   = instrWord[15:10] == 6'b000111;
  assign cmpOp   = instrWord[15:11] == 5'b01100 && instrWord[10:9] != 2'b11;
  assign fileSel = instrWord[7:0];
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_quiet;
    !(memWrEn || accWrEn || nzWrEn || carryWrEn);
  endsequence
  sequence s_discardOne;
    discardNext[*4] ##1 !discardNext;
  endsequence
  sequence s_discardTwo;
    discardNext[*8] ##1 !discardNext;
  endsequence
  chk_inv_decode: assert property (go && invOp
    |=> handled && memReadEn ##2 nzWrEn && !carryWrEn)
    else $error("invert did not run");
  chk_inv_file: assert property (go && invOp && instrWord[9]
    |=> ##2 memWrEn && !accWrEn)
    else $error("invert missed file write");
  chk_inv_acc: assert property (go && invOp && !instrWord[9]
    |=> ##2 accWrEn && !memWrEn)
    else $error("invert missed accumulator write");
  chk_bcd_decode: assert property (go && instrWord == 16'h0007
    |=> handled && !memReadEn ##2 accWrEn && carryWrEn && !nzWrEn)
    else $error("adjust did not run");
  chk_cmp_quiet: assert property (go && cmpOp
    |=> memReadEn ##2 s_quiet)
    else $error("compare wrote something");
  chk_bank_addr: assert property (go && (invOp || cmpOp) && instrWord[8]
    |=> memAddr == {$past(bankPointer), $past(fileSel)})
    else $error("banked address wrong");
  chk_skip_one: assert property ($rose(discardNext) && !$past(nextTwoWord)
    |-> s_discardOne)
    else $error("single skip length wrong");
  chk_skip_two: assert property ($rose(discardNext) && $past(nextTwoWord)
    |-> s_discardTwo)
    else $error("double skip length wrong");
  chk_discard_mute: assert property (cycleStart && discardNext
    |=> !handled && !memReadEn)
    else $error("discarded word acted on");
  chk_cycle_period: assert property (cycleStart
    |=> !cycleStart[*3] ##1 cycleStart)
    else $error("instruction cycle not four clocks");
endmodule : ccsb_core_chk

bind ccsb_core ccsb_core_chk i_chk (
  .clk(clk), .rst_n(rst_n), .instrWord(instrWord),
  .nextTwoWord(nextTwoWord), .bankPointer(bankPointer),
  .cycleStart(cycleStart), .handled(handled), .memAddr(memAddr),
  .memReadEn(memReadEn), .memWrEn(memWrEn), .accWrEn(accWrEn),
  .nzWrEn(nzWrEn), .carryWrEn(carryWrEn), .discardNext(discardNext)
);

// *** dv/ccsb_mem_model.sv ***
// Purpose: Data memory behind the core's file read and write strobes
// Assumes: Each byte starts as the low byte of its address
// Notes:   Read data is presented on the falling edge of Q2
module ccsb_mem_model (
  input wire logic        clk,
  input wire logic [11:0] memAddr,
  input wire logic        memReadEn,
  input wire logic [7:0]  memWrData,
  input wire logic        memWrEn,
  output logic [7:0]      fileData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4096];
  initial begin
    foreach (mem[i]) mem[i] = i[7:0];
  end
  always @(posedge clk) begin
    if (memWrEn) mem[memAddr] <= memWrData;
  end
  // Outside a read the bus shows the inverse, so stale data cannot pass
  always @(negedge clk) begin
    fileData <= memReadEn ? mem[memAddr] : ~mem[memAddr];
  end
endmodule : ccsb_mem_model

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the invert, compare-skip and adjust core
// Assumes: One instruction per four clocks, issued in the Q1 low phase
// Notes:   Expected values come from a reference model kept here
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, nextTwoWord, carryIn, halfCarryFlag, extendedEn;
  logic [15:0] instrWord, rnd, w;
  logic [7:0]  fileData, accumulatorReg, memWrData, accWrData;
  logic [3:0]  bankPointer;
  logic [11:0] indexBase, memAddr;
  logic        cycleStart, handled, memReadEn, memWrEn, accWrEn, negFlag;
  logic        zeroFlag, nzWrEn, carryFlag, carryWrEn, discardNext;
  logic [7:0]  bmem [4096];
  logic [15:0] ops [8] = '{16'h1C00, 16'h1E00, 16'h6200, 16'h6400,
                           16'h6000, 16'h0007, 16'h7000, 16'h6200};
  int          failures, n_compared, skip;

  ccsb_core i_dut (
    .clk(clk), .rst_n(rst_n), .instrWord(instrWord),
    .nextTwoWord(nextTwoWord), .fileData(fileData),
    .accumulatorReg(accumulatorReg), .carryIn(carryIn),
    .halfCarryFlag(halfCarryFlag), .bankPointer(bankPointer),
    .extendedEn(extendedEn), .indexBase(indexBase),
    .cycleStart(cycleStart), .handled(handled), .memAddr(memAddr),
    .memReadEn(memReadEn), .memWrData(memWrData), .memWrEn(memWrEn),
    .accWrData(accWrData), .accWrEn(accWrEn), .negFlag(negFlag),
    .zeroFlag(zeroFlag), .nzWrEn(nzWrEn), .carryFlag(carryFlag),
    .carryWrEn(carryWrEn), .discardNext(discardNext)
  );
  ccsb_mem_model i_mem (
    .clk(clk), .memAddr(memAddr), .memReadEn(memReadEn),
    .memWrData(memWrData), .memWrEn(memWrEn), .fileData(fileData)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [11:0] addrOf(input logic [15:0] x);
    if (x[8]) return {bankPointer, x[7:0]};
    if (extendedEn && x[7:0] <= 8'h5F) return indexBase + x[7:0];
    return {(x[7:0] < 8'h60) ? 4'h0 : 4'hF, x[7:0]};
  endfunction : addrOf

  task automatic summarize();
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // One instruction cycle, entered and left in the Q1 low phase
  // ----------------------------------------------------------------
  task automatic exec(input logic [15:0] x);
    logic [11:0] a;
    logic [7:0]  f, r;
    logic        isF, isC, isB, sk;
    int          lo, hi;
    a   = addrOf(x);
    f   = bmem[a];
    r   = ~f;
    isF = skip == 0 && x[15:10] == 6'b000111;
    isC = skip == 0 && x[15:11] == 5'b01100 && x[10:9] != 2'b11;
    isB = skip == 0 && x == 16'h0007;
    sk  = isC && (x[10:9] == 2'b01 ? f == accumulatorReg :
          x[10] ? f > accumulatorReg : f < accumulatorReg);
    instrWord = x;
    @(posedge clk);
    @(negedge clk);
    `CHK("handled", isF | isC | isB, handled)
    `CHK("discard", skip != 0, discardNext)
    `CHK("start", 1'b0, cycleStart)
    `CHK("read", isF | isC, memReadEn)
    if (isF | isC) `CHK("addr", a, memAddr)
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("fileWr", isF & x[9], memWrEn)
    `CHK("accWr", isF & !x[9] | isB, accWrEn)
    `CHK("nzWr", isF, nzWrEn)
    `CHK("cWr", isB, carryWrEn)
    if (isF) begin
      `CHK("neg", r[7], negFlag)
      `CHK("zero", r == 8'h00, zeroFlag)
      `CHK("data", r, x[9] ? memWrData : accWrData)
      if (x[9]) bmem[a] = r;
    end
    if (isB) begin
      lo = accumulatorReg[3:0];
      if (lo > 9 || halfCarryFlag) lo += 6;
      hi = accumulatorReg[7:4] + halfCarryFlag;
      if (hi > 9 || carryIn) hi += 6;
      `CHK("bcd", ({hi[3:0], lo[3:0]}), accWrData)
      `CHK("carry", hi > 15 || carryIn, carryFlag)
    end
    if (skip > 0) skip--;
    if (sk) skip = nextTwoWord ? 2 : 1;
    @(posedge clk);
    @(negedge clk);
    `CHK("start", 1'b1, cycleStart)
  endtask : exec

  initial begin
    {rst_n, nextTwoWord, carryIn, halfCarryFlag, extendedEn} = 5'h00;
    {instrWord, accumulatorReg, bankPointer, indexBase} = 40'h0;
    failures = 0;
    n_compared = 0;
    skip = 0;
    rnd = 16'h004D;
    foreach (bmem[i]) bmem[i] = i[7:0];
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHK("start", 1'b0, cycleStart)
    // Zero byte inverted twice gives a full then an empty result
    exec(16'h1E00);
    exec(16'h1E00);
    accumulatorReg = 8'hA5;
    exec(16'h0007);
    for (int i = 0; i < 600; i++) begin
      rnd = lfsr(rnd);
      {bankPointer, extendedEn, nextTwoWord, carryIn, halfCarryFlag} = rnd[7:0];
      indexBase = rnd[15:4];
      rnd = lfsr(rnd);
      w = ops[rnd[2:0]];
      if (w != 16'h0007) w = w | {7'h00, rnd[3], rnd[15:8]};
      accumulatorReg = rnd[2:0] == 3'd7 ? bmem[addrOf(w)] : rnd[11:4];
      exec(w);
    end
    summarize();
  end
endmodule : testbench
